// file: shared/pae_pkg.sv
// Constants, carrier types and register map of the process alarm evaluator.
package pae_pkg;

    // ==========================================================================
    // Sizes and timing
    localparam int NCH        = 3;
    localparam int NAUX       = 3;
    localparam int AW         = 12;
    localparam int TICK_W     = 25;
    localparam int SEC_S      = 1;
    localparam int CLK_HZ     = 25_000_000;
    localparam int SEC_CYCLES = SEC_S * CLK_HZ;

    // ==========================================================================
    // Register map (byte addresses) and field positions
    localparam logic [11:0] A_CTRL    = 12'h000;
    localparam logic [11:0] A_STATUS  = 12'h004;
    localparam logic [11:0] A_AUXMAP  = 12'h008;
    localparam logic [4:0]  O_TYPE    = 5'h00;
    localparam logic [4:0]  O_AVAL    = 5'h04;
    localparam logic [4:0]  O_UPPER   = 5'h08;
    localparam logic [4:0]  O_LOWER   = 5'h0c;
    localparam logic [4:0]  O_ON      = 5'h10;
    localparam logic [4:0]  O_OFF     = 5'h14;
    localparam int          C_HEATCOOL = 0;
    localparam int          C_RSPUSED  = 1;
    localparam int          C_REASSIGN = 2;
    localparam int          S_RAW      = 0;
    localparam int          S_OUT      = 4;
    localparam int          S_AUX      = 8;

    // ==========================================================================
    // Reset values, limits, alarm type codes and bus response codes
    localparam logic [4:0]  TYPE_RST   = 5'h02;
    localparam logic [5:0]  AUXMAP_RST = 6'h24;
    localparam logic [9:0]  DLY_MAX    = 10'h3e7;
    localparam logic [4:0]  TYPE_MAX   = 5'h13;
    localparam logic [4:0]  T_LBA      = 5'h0c;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLV   = 2'h2;

    // ==========================================================================
    // Carriers
    typedef struct packed {
        logic signed [15:0] process_value;
        logic signed [15:0] set_point;
        logic signed [15:0] remote_set_point;
        logic signed [15:0] manipulated_value;
        logic signed [15:0] heat_mv;
        logic signed [15:0] cool_mv;
    } pae_samp_s;

    typedef struct packed {
        logic [4:0]         typ;
        logic signed [15:0] aval;
        logic signed [15:0] upper;
        logic signed [15:0] lower;
        logic [9:0]         on_dly;
        logic [9:0]         off_dly;
        logic               stby;
        logic               raw;
        logic               out;
        logic [9:0]         cnt;
    } pae_chan_s;

    typedef struct packed {
        pae_chan_s [NCH-1:0]     ch;
        logic [2:0]              ctrl;
        logic [NAUX-1:0][1:0]    amap;
        logic [NAUX-1:0]         aux;
        logic [TICK_W-1:0]       tick;
        logic                    sec;
        logic                    ha1;
        logic                    ha2;
        logic                    hf1;
        logic                    hf2;
        logic [11:0]             awa;
        logic                    awh;
        logic [31:0]             wd;
        logic [3:0]              ws;
        logic                    wh;
        logic                    awr;
        logic                    wr;
        logic                    bv;
        logic [1:0]              br;
        logic                    arr;
        logic                    rv;
        logic [31:0]             rd;
        logic [1:0]              rr;
    } pae_state_s;

endpackage : pae_pkg

// file: design/pae_alarm_eval.sv
// Alarm evaluator with delay stage, auxiliary routing and AXI4-Lite registers.
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module pae_alarm_eval #(
    parameter int TICK_CYCLES = pae_pkg::SEC_CYCLES
) (
    // Clock and reset
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    // AXI4-Lite slave
    input  wire logic [11:0]                 awaddr,
    input  wire logic                        awvalid,
    output logic                             awready,
    input  wire logic [31:0]                 wdata,
    input  wire logic [3:0]                  wstrb,
    input  wire logic                        wvalid,
    output logic                             wready,
    output logic [1:0]                       bresp,
    output logic                             bvalid,
    input  wire logic                        bready,
    input  wire logic [11:0]                 araddr,
    input  wire logic                        arvalid,
    output logic                             arready,
    output logic [31:0]                      rdata,
    output logic [1:0]                       rresp,
    output logic                             rvalid,
    input  wire logic                        rready,
    // Process samples
    input  wire pae_pkg::pae_samp_s          samp,
    input  wire logic                        sample_valid,
    // Heater detection pins
    input  wire logic                        heater_fitted,
    input  wire logic                        heater_alarm,
    // Auxiliary outputs
    output logic [pae_pkg::NAUX-1:0]         aux_out
);

    pae_pkg::pae_state_s q;
    pae_pkg::pae_state_s d;
    logic                wr_go;
    logic                wr_err;
    int                  wr_ch;
    logic [31:0]         wv;

    // ==========================================================================
    // Alarm condition
    function automatic logic eval(input pae_pkg::pae_chan_s c, input pae_pkg::pae_samp_s s,
                                  input logic [2:0] ctl);
        logic signed [17:0] pv;
        logic signed [17:0] sp;
        logic signed [17:0] av;
        logic signed [17:0] up;
        logic signed [17:0] lo;
        logic               hc;
        logic [4:0]         t;
        pv = 18'(s.process_value);
        sp = 18'(s.set_point);
        av = 18'(c.aval);
        up = 18'(c.upper);
        lo = 18'(c.lower);
        hc = ctl[pae_pkg::C_HEATCOOL];
        t  = c.typ;
        // Standby variants share the plain comparisons.
        unique case (c.typ)
            5'h05: t = 5'h01;
            5'h06: t = 5'h02;
            5'h07: t = 5'h03;
            5'h0a: t = 5'h08;
            5'h0b: t = 5'h09;
            default: t = c.typ;
        endcase
        if (c.typ == 5'h05 && (up + lo) < 18'sh0)
            return 1'b0;
        unique case (t)
            5'h01: return (pv > sp + up) || (pv < sp - lo);
            5'h02: return (pv - sp) >= av;
            5'h03: return (sp - pv) >= av;
            5'h04: return (pv >= sp - lo) && (pv <= sp + up);
            5'h08: return pv > av;
            5'h09: return pv < av;
            5'h0e: return sp > av;
            5'h0f: return sp < av;
            5'h10: return hc ? (av < 18'sh0 || 18'(s.heat_mv) > av)
                             : 18'(s.manipulated_value) > av;
            5'h11: return hc ? (av < 18'sh0 || 18'(s.cool_mv) < av)
                             : 18'(s.manipulated_value) < av;
            5'h12: return ctl[pae_pkg::C_RSPUSED] && 18'(s.remote_set_point) > av;
            5'h13: return ctl[pae_pkg::C_RSPUSED] && 18'(s.remote_set_point) < av;
            // Off, loop burnout and change rate have no comparison here.
            default: return 1'b0;
        endcase
    endfunction : eval

    function automatic logic stby_type(input logic [4:0] t);
        return t == 5'h05 || t == 5'h06 || t == 5'h07 || t == 5'h0a || t == 5'h0b;
    endfunction : stby_type

    // ==========================================================================
    // Register read: {error, data}
    function automatic logic [32:0] rd_reg(input pae_pkg::pae_state_s s, input logic [11:0] a);
        logic [31:0] r;
        logic        hide;
        int          c;
        r    = 32'h0;
        hide = s.hf2 && !s.ctrl[pae_pkg::C_REASSIGN];
        c    = int'(a[11:5]) - 1;
        if (a[11:2] == pae_pkg::A_CTRL[11:2])
            r[2:0] = s.ctrl;
        else if (a[11:2] == pae_pkg::A_STATUS[11:2])
        begin
            for (int i = 0; i < pae_pkg::NCH; i++)
            begin
                r[pae_pkg::S_RAW + i] = s.ch[i].raw;
                r[pae_pkg::S_OUT + i] = s.ch[i].out;
            end
            r[pae_pkg::S_AUX +: pae_pkg::NAUX] = s.aux;
        end
        else if (a[11:2] == pae_pkg::A_AUXMAP[11:2])
            r[5:0] = s.amap;
        else if (c >= 0 && c < pae_pkg::NCH)
        begin
            unique case ({a[4:2], 2'b00})
                pae_pkg::O_TYPE:  r[4:0] = (c == 0 && hide) ? 5'h00 : s.ch[c].typ;
                pae_pkg::O_AVAL:  r = 32'(s.ch[c].aval);
                pae_pkg::O_UPPER: r = 32'(s.ch[c].upper);
                pae_pkg::O_LOWER: r = 32'(s.ch[c].lower);
                pae_pkg::O_ON:    r[9:0] = s.ch[c].on_dly;
                pae_pkg::O_OFF:   r[9:0] = s.ch[c].off_dly;
                default:          return {1'b1, 32'h0};
            endcase
        end
        else
            return {1'b1, 32'h0};
        return {1'b0, r};
    endfunction : rd_reg

    // ==========================================================================
    // Next state
    always_comb
    begin
        logic        hide;
        logic        cond;
        logic [9:0]  dly;
        logic [32:0] rr;
        hide   = 1'b0;
        cond   = 1'b0;
        dly    = 10'h0;
        rr     = 33'h0;
        d      = q;
        wr_go  = 1'b0;
        wr_err = 1'b0;
        wr_ch  = 0;
        wv     = 32'h0;
        d.ha1  = heater_alarm;
        d.ha2  = q.ha1;
        d.hf1  = heater_fitted;
        d.hf2  = q.hf1;
        hide   = q.hf2 && !q.ctrl[pae_pkg::C_REASSIGN];
        d.sec  = 1'b0;
        if (q.tick >= pae_pkg::TICK_W'(TICK_CYCLES - 1))
        begin
            d.tick = '0;
            d.sec  = 1'b1;
        end
        else
            d.tick = q.tick + 1'b1;

        for (int i = 0; i < pae_pkg::NCH; i++)
        begin
            if (sample_valid)
            begin
                cond = eval(q.ch[i], samp, q.ctrl);
                if (!cond)
                    d.ch[i].stby = 1'b0;
                d.ch[i].raw = cond && !(stby_type(q.ch[i].typ) && q.ch[i].stby);
            end
            dly = q.ch[i].raw ? q.ch[i].on_dly : q.ch[i].off_dly;
            if (q.ch[i].raw == q.ch[i].out)
                d.ch[i].cnt = 10'h0;
            else if (q.ch[i].cnt >= dly)
            begin
                d.ch[i].out = q.ch[i].raw;
                d.ch[i].cnt = 10'h0;
            end
            else if (q.sec)
                d.ch[i].cnt = q.ch[i].cnt + 10'h1;
        end

        for (int k = 0; k < pae_pkg::NAUX; k++)
        begin
            if (q.amap[k] == 2'h0)
                d.aux[k] = hide ? q.ha2 : q.ch[0].out;
            else if (int'(q.amap[k]) < pae_pkg::NCH)
                d.aux[k] = q.ch[q.amap[k]].out;
            else
                d.aux[k] = 1'b0;
        end

        // Write channel: address and data are taken in either order.
        if (awvalid && q.awr)
        begin
            d.awa = awaddr;
            d.awh = 1'b1;
        end
        if (wvalid && q.wr)
        begin
            d.wd  = wdata;
            d.ws  = wstrb;
            d.wh  = 1'b1;
        end
        if (bready && q.bv)
            d.bv = 1'b0;
        if (q.awh && q.wh && !q.bv)
        begin
            wr_go = 1'b1;
            rr    = rd_reg(q, q.awa);
            wr_ch = int'(q.awa[11:5]) - 1;
            for (int b = 0; b < 4; b++)
                wv[8*b +: 8] = q.ws[b] ? q.wd[8*b +: 8] : rr[8*b +: 8];
            wr_err = rr[32];
            if (q.awa[11:2] == pae_pkg::A_CTRL[11:2])
                d.ctrl = wv[2:0];
            else if (q.awa[11:2] == pae_pkg::A_AUXMAP[11:2])
                d.amap = wv[5:0];
            else if (q.awa[11:2] == pae_pkg::A_STATUS[11:2])
                wr_err = 1'b1;
            else if (!wr_err)
            begin
                unique case ({q.awa[4:2], 2'b00})
                    pae_pkg::O_TYPE:
                    begin
                        // Hidden type and illegal codes are refused, not clipped.
                        if (wv[31:5] != 27'h0 || wv[4:0] > pae_pkg::TYPE_MAX
                            || (wr_ch == 0 && hide))
                            wr_err = 1'b1;
                        else if (wv[4:0] == pae_pkg::T_LBA && wr_ch != 0)
                            wr_err = 1'b1;
                        else
                        begin
                            d.ch[wr_ch].typ  = wv[4:0];
                            d.ch[wr_ch].stby = 1'b1;
                        end
                    end
                    pae_pkg::O_AVAL:  d.ch[wr_ch].aval  = wv[15:0];
                    pae_pkg::O_UPPER: d.ch[wr_ch].upper = wv[15:0];
                    pae_pkg::O_LOWER: d.ch[wr_ch].lower = wv[15:0];
                    default:
                    begin
                        if (wv > 32'(pae_pkg::DLY_MAX))
                            wr_err = 1'b1;
                        else if (q.awa[4:2] == pae_pkg::O_ON[4:2])
                            d.ch[wr_ch].on_dly = wv[9:0];
                        else
                            d.ch[wr_ch].off_dly = wv[9:0];
                    end
                endcase
            end
            d.awh = 1'b0;
            d.wh  = 1'b0;
            d.bv  = 1'b1;
            d.br  = wr_err ? pae_pkg::RESP_SLV : pae_pkg::RESP_OKAY;
        end

        // Read channel: one cycle from address to data.
        if (rready && q.rv)
            d.rv = 1'b0;
        if (arvalid && q.arr)
        begin
            rr   = rd_reg(q, araddr);
            d.rv = 1'b1;
            d.rd = rr[31:0];
            d.rr = rr[32] ? pae_pkg::RESP_SLV : pae_pkg::RESP_OKAY;
        end
        d.awr = !d.awh && !d.bv;
        d.wr  = !d.wh && !d.bv;
        d.arr = !d.rv;

        if (!aresetn)
        begin
            d = '0;
            for (int i = 0; i < pae_pkg::NCH; i++)
            begin
                d.ch[i].typ  = pae_pkg::TYPE_RST;
                d.ch[i].stby = 1'b1;
            end
            d.amap = pae_pkg::AUXMAP_RST;
        end
    end

    always_ff @(posedge aclk)
    begin
        q <= d;
    end

    assign awready = q.awr;
    assign wready  = q.wr;
    assign bvalid  = q.bv;
    assign bresp   = q.br;
    assign arready = q.arr;
    assign rvalid  = q.rv;
    assign rdata   = q.rd;
    assign rresp   = q.rr;
    assign aux_out = q.aux;

    // ==========================================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_samp(logic [4:0] t);
        sample_valid && q.ch[1].typ == t;
    endsequence

    type_off_a: assert property (s_samp(5'h00) |=> !q.ch[1].raw)
        else $error("Disabled alarm raised its raw state.");
    dev_upper_a: assert property (s_samp(5'h02) ##0 ((18'(samp.process_value)
        - 18'(samp.set_point)) >= 18'(q.ch[1].aval)) |=> q.ch[1].raw)
        else $error("Upper deviation alarm missed.");
    abs_upper_a: assert property (s_samp(5'h08)
        ##0 (samp.process_value > q.ch[1].aval) |=> q.ch[1].raw)
        else $error("Absolute upper alarm missed.");
    mv_negative_a: assert property (s_samp(5'h10) ##0 (q.ctrl[pae_pkg::C_HEATCOOL]
        && q.ch[1].aval < 16'sh0) |=> q.ch[1].raw)
        else $error("Heating/cooling MV alarm not held on.");
    rsp_unused_a: assert property (s_samp(5'h12) ##0 !q.ctrl[pae_pkg::C_RSPUSED]
        |=> !q.ch[1].raw)
        else $error("Remote set point alarm without remote input.");
    zero_delay_a: assert property (q.ch[1].raw && !q.ch[1].out
        && q.ch[1].on_dly == 10'h0 |=> q.ch[1].out)
        else $error("Zero ON delay did not pass at once.");
    hold_delay_a: assert property (q.ch[1].raw != q.ch[1].out
        && q.ch[1].cnt < (q.ch[1].raw ? q.ch[1].on_dly : q.ch[1].off_dly)
        |=> q.ch[1].out == $past(q.ch[1].out))
        else $error("Output changed before its delay ran out.");
    aux_route_a: assert property (q.amap[0] == 2'h1 ##1 q.amap[0] == 2'h1
        |-> aux_out[0] == $past(q.ch[1].out))
        else $error("Auxiliary output not following its channel.");
    lba_reject_a: assert property (wr_go && wr_ch == 1 && q.awa[4:0] == pae_pkg::O_TYPE
        && wv == 32'h0000000c |=> q.ch[1].typ == $past(q.ch[1].typ)
        && bresp == pae_pkg::RESP_SLV)
        else $error("Loop burnout type taken on a later channel.");

endmodule : pae_alarm_eval

// file: testbench/pae_alarm_eval_test.sv
// Self-checking bench for the process alarm evaluator.
`timescale 1ns/1ps
module pae_alarm_eval_test;
    localparam int TK = 10;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sample_valid;
    logic heater_fitted, heater_alarm, awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [2:0]  aux_out;
    pae_pkg::pae_samp_s samp;
    int          n_mismatch, n_tests, p, s, a, t, n;
    logic [65:0] exq[$];
    logic [65:0] ex_note;
    int tb [26][7] = '{'{0,100,0,0,0,0,0}, '{1,11,0,0,1,0,0}, '{1,10,0,0,0,0,0},
        '{1,-11,0,0,1,0,0}, '{2,15,10,5,1,0,0}, '{2,14,10,5,0,0,0}, '{3,5,10,5,1,0,0},
        '{4,10,0,0,1,0,0}, '{4,11,0,0,0,0,0}, '{8,6,0,5,1,0,0}, '{8,5,0,5,0,0,0},
        '{9,4,0,5,1,0,0}, '{13,0,0,0,0,0,0}, '{14,0,6,5,1,0,0}, '{15,0,4,5,1,0,0},
        '{16,0,6,5,1,0,0}, '{17,0,4,5,1,0,0}, '{18,0,6,5,0,0,0}, '{18,0,6,5,1,0,2},
        '{19,0,4,5,1,0,2}, '{16,0,-100,-5,1,0,1}, '{5,11,0,0,1,0,0},
        '{6,15,10,5,1,10,0}, '{7,5,10,5,1,10,0}, '{10,6,0,5,1,0,0}, '{11,4,0,5,1,10,0}};

    pae_alarm_eval #(.TICK_CYCLES(TK)) dut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .samp(samp),
        .sample_valid(sample_valid), .heater_fitted(heater_fitted),
        .heater_alarm(heater_alarm), .aux_out(aux_out));

    // ==========================================================================
    // Clock, checking and closing
    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic test_done;
        $display("comparisons=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    task automatic chk(input logic [33:0] sn, input logic [33:0] ex);
        n_tests++;
        if (sn !== ex)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, sn, ex);
        end
    endtask : chk

    // The watcher pairs each bus answer with the oldest expectation noted.
    always @(posedge aclk)
    begin
        if ((bvalid && bready) || (rvalid && rready))
        begin
            if (exq.size() == 0)
                chk(34'h0, 34'h3_ffff_ffff);
            else
            begin
                ex_note = exq.pop_front();
                if (bvalid)
                    chk({bresp, 32'h0}, ex_note[33:0]);
                else
                    chk({rresp, rdata & ex_note[65:34]}, ex_note[33:0]);
            end
        end
    end

    // ==========================================================================
    // Bus and sample tasks
    task automatic wait_end(input int m);
        if (m >= 200)
        begin
            n_mismatch++;
            test_done();
        end
    endtask : wait_end

    task automatic wr(input logic [11:0] ad, input logic [31:0] d, input logic [1:0] r);
        int m;
        logic bd;
        exq.push_back({32'h0, r, 32'h0});
        awaddr <= ad;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        bd = 1'b0;
        for (m = 0; m < 200 && !bd; m++)
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            bd = bvalid;
        end
        wait_end(bd ? 0 : m);
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [11:0] ad, input logic [31:0] k, input logic [31:0] d,
                      input logic [1:0] r);
        int m;
        logic rdn;
        exq.push_back({k, r, d});
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        rdn = 1'b0;
        for (m = 0; m < 200 && !rdn; m++)
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            rdn = rvalid;
        end
        wait_end(rdn ? 0 : m);
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    task automatic smp(input int pa, input int pb);
        samp <= {pa[15:0], {5{pb[15:0]}}};
        sample_valid <= 1'b1;
        @(posedge aclk);
        sample_valid <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask : smp

    // Raw bit of channel 1 and the auxiliary output routed to it by default.
    task automatic st(input logic e);
        rd(12'h004, 32'h202, {22'h0, e, 7'h0, e, 1'b0}, 2'h0);
    endtask : st

    // ==========================================================================
    // Main sequence
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready, sample_valid} = '0;
        {heater_fitted, heater_alarm, awaddr, araddr, wdata, wstrb} = '0;
        samp = '0;
        aresetn = 1'b0;
        n_mismatch = 0;
        n_tests = 0;
        void'($urandom(32'h5296));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(12'h040, 32'hffffffff, 32'h2, 2'h0);
        rd(12'h008, 32'hffffffff, 32'h24, 2'h0);
        rd(12'hffc, 32'hffffffff, 32'h0, 2'h2);
        wr(12'h040, 32'd20, 2'h2);
        wr(12'h040, 32'd12, 2'h2);
        rd(12'h040, 32'hffffffff, 32'h2, 2'h0);
        wr(12'h020, 32'd12, 2'h0);
        wr(12'h050, 32'd1000, 2'h2);
        wr(12'h050, 32'd999, 2'h0);
        rd(12'h050, 32'hffffffff, 32'd999, 2'h0);
        wr(12'h050, 32'd0, 2'h0);
        wr(12'h004, 32'h0, 2'h2);
        $display("test registers done");
        wr(12'h048, 32'd10, 2'h0);
        wr(12'h04c, 32'd10, 2'h0);
        foreach (tb[i])
        begin
            wr(12'h000, tb[i][6], 2'h0);
            wr(12'h040, tb[i][0], 2'h0);
            wr(12'h044, tb[i][3], 2'h0);
            if (tb[i][0] inside {5, 6, 7, 10, 11})
            begin
                smp(tb[i][1], tb[i][2]);
                st(1'b0);
                smp(tb[i][5], tb[i][2]);
            end
            smp(tb[i][1], tb[i][2]);
            st(tb[i][4][0]);
        end
        $display("test alarm types done");
        wr(12'h000, 32'h0, 2'h0);
        for (int j = 0; j < 16; j++)
        begin
            t = (j % 4 < 2) ? 2 + j % 4 : 6 + j % 4;
            p = $urandom_range(40) - 20;
            s = $urandom_range(40) - 20;
            a = $urandom_range(10);
            wr(12'h040, t, 2'h0);
            wr(12'h044, a, 2'h0);
            smp(p, s);
            st(t == 2 ? p - s >= a : t == 3 ? s - p >= a : t == 8 ? p > a : p < a);
        end
        $display("test random samples done");
        wr(12'h040, 32'd8, 2'h0);
        wr(12'h044, 32'd5, 2'h0);
        wr(12'h050, 32'd2, 2'h0);
        smp(0, 0);
        smp(10, 0);
        for (n = 0; n < 100 && !aux_out[1]; n++) @(posedge aclk);
        chk({33'h0, n >= TK - 4 && n <= 2 * TK + 4}, 34'h1);
        wr(12'h008, 32'h35, 2'h0);
        repeat (3) @(posedge aclk);
        chk({31'h0, aux_out}, 34'h3);
        wr(12'h008, 32'h24, 2'h0);
        $display("test delay and routing done");
        heater_fitted <= 1'b1;
        heater_alarm <= 1'b1;
        repeat (6) @(posedge aclk);
        chk({33'h0, aux_out[0]}, 34'h1);
        wr(12'h020, 32'd8, 2'h2);
        rd(12'h020, 32'hffffffff, 32'h0, 2'h0);
        heater_alarm <= 1'b0;
        repeat (6) @(posedge aclk);
        chk({33'h0, aux_out[0]}, 34'h0);
        wr(12'h000, 32'h4, 2'h0);
        wr(12'h020, 32'd9, 2'h0);
        rd(12'h020, 32'hffffffff, 32'd9, 2'h0);
        $display("test heater alarm done");
        // Heating output below the value while the plain MV is above it must stay quiet.
        wr(12'h000, 32'h1, 2'h0);
        wr(12'h040, 32'd16, 2'h0);
        samp <= {16'h0, 16'h0, 16'h0, 16'h9, 16'h0, 16'h9};
        sample_valid <= 1'b1;
        @(posedge aclk);
        sample_valid <= 1'b0;
        repeat (3) @(posedge aclk);
        st(1'b0);
        // Standby is cleared first, then the bands are made to overlap.
        wr(12'h000, 32'h0, 2'h0);
        wr(12'h04c, 32'd10, 2'h0);
        wr(12'h040, 32'd5, 2'h0);
        smp(0, 0);
        wr(12'h04c, -32'sd11, 2'h0);
        smp(20, 0);
        st(1'b0);
        $display("test mv split and overlap done");
        test_done();
    end
endmodule : pae_alarm_eval_test
